// [core/smbus_timing_core.sv]
// Timing core of a two-wire serial master: SCL generation, SDA spacing, timeouts.
// Assumes an APB master on core_clk_i and open-drain SCL/SDA resolved outside.
// How it works
// - Source tick used only as master or free-detect
// - Two-bit field picks one of four overflows
// - SCL low and high at least one tick
// - One bit per three ticks, high two
// - Bit rate never above minimum-time limit
// - Stretched SCL extends our low phase; contended SCL ends our high phase early
// - Normal spacing: setup one clock, hold three
// - Extended spacing: setup eleven, hold twelve clocks
// - Setup ends at SCL rise, hold starts at fall
// - Software delay lasts until flag is cleared
// - Software delay applies to MSB and ack
// - Timeout timer reloads high, counts while low
// - Bus free after over ten high ticks
`timescale 1ns/1ps
module smbus_timing_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] overflow_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic tmo_reload_o,
    output logic tmo_count_o,
    output logic bus_free_o
);
    line_sense_if lines ();

    line_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i (rst_i),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .lines (lines.sync_mp)
    );

    tick_select u_tick (
        .overflow_i (overflow_i),
        .lines (lines.tick_mp)
    );

    // ****************************************
    // APB register file
    // ****************************************
    logic [5:0] ctrl_q, ctrl_d;
    logic [7:0] tx_q, tx_d;
    logic ack_q, ack_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] rx_q, rx_d;
    logic flag_q, flag_d;
    logic wr_en, map_hit, flag_set;
    logic master_en, ext_hold, tmo_en, free_en;

    assign master_en = ctrl_q[smbus_timing_pkg::CTRL_MASTER_EN];
    assign ext_hold = ctrl_q[smbus_timing_pkg::CTRL_EXT_HOLD];
    assign tmo_en = ctrl_q[smbus_timing_pkg::CTRL_TMO_EN];
    assign free_en = ctrl_q[smbus_timing_pkg::CTRL_FREE_EN];
    assign lines.tick_sel = ctrl_q[smbus_timing_pkg::CTRL_SRC_LO +: 2];
    assign lines.tick_gate = master_en | free_en;

    assign map_hit = (paddr_i == smbus_timing_pkg::CTRL_OFS) ||
                     (paddr_i == smbus_timing_pkg::DATA_OFS) ||
                     (paddr_i == smbus_timing_pkg::STAT_OFS);
    assign wr_en = psel_i & penable_i & pwrite_i & map_hit;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~map_hit;
    assign prdata_o = prdata_q;

    // ****************************************
    // Bit engine state
    // ****************************************
    smbus_timing_pkg::eng_state_t state_q, state_d;
    logic [3:0] bit_q, bit_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] tick_cnt_q, tick_cnt_d;
    logic scl_drv_q, scl_drv_d;
    logic sda_drv_q, sda_drv_d;
    logic [3:0] free_cnt_q, free_cnt_d;
    logic bus_free_q, bus_free_d;
    logic tmo_rl_q, tmo_rl_d, tmo_ct_q, tmo_ct_d;
    logic cur_bit;
    logic [3:0] hold_len, setup_len;
    logic [3:0] cnt_inc;

    always_comb
    begin
        prdata_d = 32'h0000_0000;
        if (psel_i && !penable_i)
        begin
            case (paddr_i)
                smbus_timing_pkg::CTRL_OFS: prdata_d = {26'h000_0000, ctrl_q};
                smbus_timing_pkg::DATA_OFS: prdata_d = {24'h00_0000, rx_q};
                smbus_timing_pkg::STAT_OFS:
                begin
                    prdata_d[smbus_timing_pkg::STAT_FLAG] = flag_q;
                    prdata_d[smbus_timing_pkg::STAT_ACK] = ack_q;
                    prdata_d[smbus_timing_pkg::STAT_FREE] = bus_free_q;
                    prdata_d[smbus_timing_pkg::STAT_SCL] = lines.scl;
                    prdata_d[smbus_timing_pkg::STAT_SDA] = lines.sda;
                    prdata_d[smbus_timing_pkg::STAT_ACK_PHASE] =
                        (bit_q == smbus_timing_pkg::ACK_BIT);
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        ctrl_d = ctrl_q;
        tx_d = tx_q;
        ack_d = ack_q;
        flag_d = flag_q;
        if (wr_en && paddr_i == smbus_timing_pkg::CTRL_OFS)
        begin
            ctrl_d = pwdata_i[smbus_timing_pkg::CTRL_W-1:0];
        end
        if (wr_en && paddr_i == smbus_timing_pkg::DATA_OFS)
        begin
            tx_d = pwdata_i[7:0];
        end
        if (wr_en && paddr_i == smbus_timing_pkg::STAT_OFS)
        begin
            ack_d = pwdata_i[smbus_timing_pkg::STAT_ACK];
            // Ack and clear in one write leaves no software delay
            if (pwdata_i[smbus_timing_pkg::STAT_FLAG])
            begin
                flag_d = 1'b0;
            end
        end
        // Hardware set wins over a clear in the same cycle
        if (flag_set)
        begin
            flag_d = 1'b1;
        end
        // Disabling the interface restarts the byte and drops the wait
        if (!master_en)
        begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= smbus_timing_pkg::CTRL_RST;
            tx_q <= 8'h00;
            ack_q <= 1'b0;
            flag_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            tx_q <= tx_d;
            ack_q <= ack_d;
            flag_q <= flag_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // SCL generation and SDA spacing
    // ****************************************
    assign cur_bit = (bit_q == smbus_timing_pkg::ACK_BIT) ? ack_q : tx_q[3'd7 - bit_q[2:0]];
    assign hold_len = ext_hold ? smbus_timing_pkg::HOLD_EXT : smbus_timing_pkg::HOLD_STD;
    assign setup_len = ext_hold ? smbus_timing_pkg::SETUP_EXT : smbus_timing_pkg::SETUP_STD;
    assign cnt_inc = (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;

    always_comb
    begin
        state_d = state_q;
        bit_d = bit_q;
        cnt_d = cnt_inc;
        tick_cnt_d = tick_cnt_q;
        scl_drv_d = scl_drv_q;
        sda_drv_d = sda_drv_q;
        rx_d = rx_q;
        flag_set = 1'b0;
        case (state_q)
            smbus_timing_pkg::S_IDLE:
            begin
                scl_drv_d = 1'b0;
                sda_drv_d = 1'b0;
                bit_d = 4'h0;
                if (master_en && !flag_q)
                begin
                    scl_drv_d = 1'b1;
                    cnt_d = 4'h0;
                    tick_cnt_d = 2'h0;
                    state_d = smbus_timing_pkg::S_HOLD;
                end
            end
            smbus_timing_pkg::S_HOLD:
            begin
                if (lines.tick)
                begin
                    tick_cnt_d = smbus_timing_pkg::LOW_TICKS;
                end
                // SDA frozen until hold spacing after the SCL fall has run out
                if (cnt_inc >= hold_len)
                begin
                    cnt_d = 4'h0;
                    state_d = smbus_timing_pkg::S_LOW;
                end
            end
            smbus_timing_pkg::S_LOW:
            begin
                if (lines.tick)
                begin
                    tick_cnt_d = smbus_timing_pkg::LOW_TICKS;
                end
                // New data is driven only once software has cleared the flag
                if (!flag_q && sda_drv_q != !cur_bit)
                begin
                    sda_drv_d = !cur_bit;
                    cnt_d = 4'h0;
                end
                else if (!flag_q && tick_cnt_q >= smbus_timing_pkg::LOW_TICKS &&
                         cnt_inc >= setup_len)
                begin
                    scl_drv_d = 1'b0;
                    state_d = smbus_timing_pkg::S_RISE;
                end
            end
            smbus_timing_pkg::S_RISE:
            begin
                // A slow slave holds SCL low; the high phase waits for it
                if (lines.scl)
                begin
                    tick_cnt_d = 2'h0;
                    rx_d = {rx_q[6:0], lines.sda};
                    state_d = smbus_timing_pkg::S_HIGH;
                end
            end
            smbus_timing_pkg::S_HIGH:
            begin
                if (lines.tick)
                begin
                    tick_cnt_d = tick_cnt_q + 2'h1;
                end
                // Ends on the second tick, or early if another master pulls SCL low
                if ((lines.tick && tick_cnt_q + 2'h1 == smbus_timing_pkg::HIGH_TICKS) ||
                    lines.scl_fall)
                begin
                    scl_drv_d = 1'b1;
                    cnt_d = 4'h0;
                    tick_cnt_d = 2'h0;
                    flag_set = (bit_q >= 4'h7);
                    bit_d = (bit_q == smbus_timing_pkg::ACK_BIT) ? 4'h0 : bit_q + 4'h1;
                    state_d = smbus_timing_pkg::S_HOLD;
                end
            end
            default:
            begin
                state_d = smbus_timing_pkg::S_IDLE;
            end
        endcase
        if (!master_en)
        begin
            state_d = smbus_timing_pkg::S_IDLE;
            scl_drv_d = 1'b0;
            sda_drv_d = 1'b0;
        end
    end

    // ****************************************
    // Free-bus detection and timeout timer gating
    // ****************************************
    always_comb
    begin
        free_cnt_d = free_cnt_q;
        if (!free_en || !lines.scl || !lines.sda)
        begin
            free_cnt_d = 4'h0;
        end
        else if (lines.tick && free_cnt_q <= smbus_timing_pkg::FREE_TICKS)
        begin
            free_cnt_d = free_cnt_q + 4'h1;
        end
        bus_free_d = (free_cnt_d > smbus_timing_pkg::FREE_TICKS);
        tmo_rl_d = tmo_en & lines.scl;
        tmo_ct_d = tmo_en & ~lines.scl;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= smbus_timing_pkg::S_IDLE;
            bit_q <= 4'h0;
            cnt_q <= 4'h0;
            tick_cnt_q <= 2'h0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            rx_q <= 8'h00;
            free_cnt_q <= 4'h0;
            bus_free_q <= 1'b0;
            tmo_rl_q <= 1'b0;
            tmo_ct_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            tick_cnt_q <= tick_cnt_d;
            scl_drv_q <= scl_drv_d;
            sda_drv_q <= sda_drv_d;
            rx_q <= rx_d;
            free_cnt_q <= free_cnt_d;
            bus_free_q <= bus_free_d;
            tmo_rl_q <= tmo_rl_d;
            tmo_ct_q <= tmo_ct_d;
        end
    end

    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_drv_q;
    assign sda_oe_o = sda_drv_q;
    assign tmo_reload_o = tmo_rl_q;
    assign tmo_count_o = tmo_ct_q;
    assign bus_free_o = bus_free_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [3:0] since_fall_h, since_sda_h;
    logic [1:0] low_ticks_h;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !scl_drv_q)
        begin
            since_fall_h <= 4'h0;
            low_ticks_h <= 2'h0;
        end
        else
        begin
            since_fall_h <= (since_fall_h == 4'hF) ? since_fall_h : since_fall_h + 4'h1;
            low_ticks_h <= (lines.tick && low_ticks_h != 2'h3) ? low_ticks_h + 2'h1
                                                                : low_ticks_h;
        end
        if (rst_i || sda_drv_d != sda_drv_q)
        begin
            since_sda_h <= 4'h0;
        end
        else
        begin
            since_sda_h <= (since_sda_h == 4'hF) ? since_sda_h : since_sda_h + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_stretched;
        state_q == smbus_timing_pkg::S_RISE && !lines.scl && master_en;
    endsequence

    sequence s_high_done;
        state_q == smbus_timing_pkg::S_HIGH && state_d == smbus_timing_pkg::S_HOLD &&
            !lines.scl_fall;
    endsequence

    a_tick_gated_off: assert property (!(master_en || free_en) |-> !lines.tick)
        else $error("tick seen while neither master nor free detect");
    a_tick_source_pick: assert property ((master_en && overflow_i[ctrl_q[2:1]]) |->
                                        lines.tick)
        else $error("selected overflow did not give a tick");
    a_low_min_tick: assert property ($fell(scl_drv_q) && master_en |->
                                    $past(low_ticks_h) >= 2'h1)
        else $error("SCL released before one low tick");
    a_high_two_ticks: assert property (s_high_done |-> tick_cnt_q == 2'h1 && lines.tick)
        else $error("high phase not ended on second tick");
    a_stretch_waits: assert property (s_stretched |=> state_q == smbus_timing_pkg::S_RISE
                                      || !master_en)
        else $error("high phase started while SCL held low");
    a_hold_spacing: assert property ($changed(sda_drv_q) && $past(scl_drv_q) && master_en |->
                                    $past(since_fall_h) >= hold_len - 4'h1)
        else $error("SDA changed inside hold spacing");
    a_setup_ext: assert property ($fell(scl_drv_q) && master_en && ext_hold |->
                                 $past(since_sda_h) >= smbus_timing_pkg::SETUP_EXT - 4'h1)
        else $error("SDA setup shorter than extended spacing");
    a_flag_blocks_rise: assert property (flag_q && state_q == smbus_timing_pkg::S_LOW |=>
                                        state_q != smbus_timing_pkg::S_RISE)
        else $error("SCL released while flag pending");
    a_flag_msb_ack: assert property (s_high_done ##0 bit_q >= 4'h7 ##1 master_en |->
                                    flag_q)
        else $error("flag not set before ack or next MSB");
    a_tmo_follow: assert property (tmo_en && lines.scl |=> tmo_reload_o && !tmo_count_o)
        else $error("timeout timer not reloaded while SCL high");
    a_free_needs_high: assert property ($rose(bus_free_o) |->
                                       $past(lines.scl && lines.sda && free_en))
        else $error("bus free without both lines high");
endmodule : smbus_timing_core

// [core/smbus_timing_pkg.sv]
// Shared constants of the two-wire timing core: register map, fields, reset values, counts.
// Assumes a 32-bit APB slave and a single core clock.
package smbus_timing_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_MASTER_EN = 0;
    localparam int CTRL_SRC_LO = 1;
    localparam int CTRL_EXT_HOLD = 3;
    localparam int CTRL_TMO_EN = 4;
    localparam int CTRL_FREE_EN = 5;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // ****************************************
    // Status fields
    // ****************************************
    localparam int STAT_FLAG = 0;
    localparam int STAT_ACK = 1;
    localparam int STAT_FREE = 2;
    localparam int STAT_SCL = 3;
    localparam int STAT_SDA = 4;
    localparam int STAT_ACK_PHASE = 5;

    // ****************************************
    // Counts in core clocks or source ticks, and the ack bit index
    // ****************************************
    localparam logic [3:0] HOLD_STD = 4'h3;
    localparam logic [3:0] HOLD_EXT = 4'hC;
    localparam logic [3:0] SETUP_STD = 4'h1;
    localparam logic [3:0] SETUP_EXT = 4'hB;
    localparam logic [1:0] LOW_TICKS = 2'h1;
    localparam logic [1:0] HIGH_TICKS = 2'h2;
    localparam logic [3:0] FREE_TICKS = 4'hA;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HOLD = 3'b001,
        S_LOW = 3'b010,
        S_RISE = 3'b011,
        S_HIGH = 3'b100
    } eng_state_t;

endpackage : smbus_timing_pkg

// [core/line_sense_if.sv]
// Carries synchronised bus levels, SCL edges and the selected tick inside the core.
// Assumes all members live on the core clock.
`timescale 1ns/1ps
interface line_sense_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic tick;
    logic [1:0] tick_sel;
    logic tick_gate;

    modport sync_mp (output scl, output sda, output scl_rise, output scl_fall);
    modport tick_mp (input tick_sel, input tick_gate, output tick);
    modport core_mp (input scl, input sda, input scl_rise, input scl_fall, input tick,
                     output tick_sel, output tick_gate);
endinterface : line_sense_if

// [core/line_sync.sv]
// Two-flop synchronisers for SCL and SDA plus SCL edge detection.
// Assumes raw pin levels from outside the core clock domain.
`timescale 1ns/1ps
module line_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    line_sense_if.sync_mp lines
);
    logic [1:0] raw;
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    assign raw = {sda_i, scl_i};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_line
            // Idle bus is high, so the chain resets high
            always_ff @(posedge core_clk_i)
            begin
                if (rst_i)
                begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end
                else
                begin
                    meta_q[g] <= raw[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    assign lines.scl = sync_q[0];
    assign lines.sda = sync_q[1];
    assign lines.scl_rise = sync_q[0] & ~prev_q[0];
    assign lines.scl_fall = ~sync_q[0] & prev_q[0];
endmodule : line_sync

// [core/tick_select.sv]
// Picks one of four overflow pulses as the bit-timing tick.
// Assumes the overflow pulses are one core clock wide and on the core clock.
`timescale 1ns/1ps
module tick_select (
    input wire logic [3:0] overflow_i,
    line_sense_if.tick_mp lines
);
    // Order: timer0, timer1, timer2 high byte, timer2 low byte
    assign lines.tick = overflow_i[lines.tick_sel] & lines.tick_gate;
endmodule : tick_select

// [tb/smbus_bus_model.sv]
// Far-side bus: pull-ups on SCL and SDA plus a slave that may stretch SCL low.
// Assumes open-drain enables from the core, paced by the core clock.
`timescale 1ns/1ps
module smbus_bus_model (
    input wire logic core_clk_i,
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    input wire logic [7:0] stretch_i,
    output logic scl_o,
    output logic sda_o
);
    logic [7:0] cnt_q = 8'h00;
    logic last_q = 1'b0;
    // ****************************************
    // Clock stretch counted from each master pull
    // ****************************************
    always @(posedge core_clk_i)
    begin
        last_q <= scl_oe_i;
        if (scl_oe_i && !last_q)
            cnt_q <= stretch_i;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    // Released lines float high through the pull-ups
    assign scl_o = !(scl_oe_i || cnt_q != 8'h00);
    assign sda_o = !sda_oe_i;
endmodule : smbus_bus_model

// [tb/test_smbus_timing_core.sv]
// Self-checking bench for the two-wire timing core: APB tasks, tick sources, bus monitor.
// Assumes zero-wait APB and one-clock overflow pulses on the core clock.
`timescale 1ns/1ps
module test_smbus_timing_core;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, e, scl, sda, scl_oe, sda_oe, t_rl, t_ct, free;
    logic [3:0] ovf = 4'h0;
    logic [7:0] stretch = 8'h00;
    logic run = 1'b0, man = 1'b0, mon = 1'b0, ext = 1'b0, tmo = 1'b0, ps = 1'b1, pd = 1'b0;
    int per [4] = '{20, 24, 28, 32};
    int errors = 0, compares = 0, cyc = 0, now = 0, lfall = 0, lsda = 0, stab = 0, lo, hi, p;

    always #12.5 core_clk_i = ~core_clk_i;

    smbus_timing_core dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .overflow_i(ovf), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .tmo_reload_o(t_rl),
        .tmo_count_o(t_ct), .bus_free_o(free));
    smbus_bus_model bus_u (.core_clk_i(core_clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
        .stretch_i(stretch), .scl_o(scl), .sda_o(sda));

    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; an idle edge follows so the strobes are never re-driven in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // Callers may return on a falling edge; start the setup after a rising one
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb

    // Low and high lengths of the next whole SCL period, in core clocks
    task automatic phase(output int l, output int h);
        l = 0;
        h = 0;
        while (scl !== 1'b1 && l < 3000) begin @(negedge core_clk_i); l++; end
        while (scl !== 1'b0 && h < 3000) begin @(negedge core_clk_i); h++; end
        l = 0;
        h = 0;
        while (scl === 1'b0 && l < 3000) begin @(negedge core_clk_i); l++; end
        while (scl === 1'b1 && h < 3000) begin @(negedge core_clk_i); h++; end
    endtask : phase

    // Timers are left running free so every source keeps its period
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++)
            ovf[i] <= (run && cyc % per[i] == 0) || man;
        if (cyc > 40000)
        begin
            errors++;
            results();
        end
    end

    // ****************************************
    // Bus monitor: SDA spacing and timeout gating
    // ****************************************
    always @(negedge core_clk_i)
    begin
        now++;
        if (scl === ps) stab++; else stab = 0;
        if (ps === 1'b1 && scl === 1'b0) lfall = now;
        if (mon && sda_oe !== pd && scl === 1'b0) chk("hold", 1, now - lfall >= (ext ? 12 : 3));
        if (sda_oe !== pd) lsda = now;
        if (mon && ps === 1'b0 && scl === 1'b1) chk("setup", 1, now - lsda >= (ext ? 11 : 1));
        if (stab > 4) chk("reload", {31'h0, tmo && scl}, {31'h0, t_rl});
        if (stab > 4) chk("count", {31'h0, tmo && !scl}, {31'h0, t_ct});
        ps = scl;
        pd = sda_oe;
    end

    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0000, q);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {31'h0, e});
        // Ticks without master or free detect must do nothing
        repeat (12) begin man <= 1'b1; @(posedge core_clk_i); man <= 1'b0; @(posedge core_clk_i); end
        chk("gated free", 32'h0, {31'h0, free});
        chk("gated scl", 32'h0, {31'h0, scl_oe});
        apb(1'b1, 8'h00, 32'h0000_0020);
        repeat (10) begin man <= 1'b1; @(posedge core_clk_i); man <= 1'b0; @(posedge core_clk_i); end
        chk("free at ten", 32'h0, {31'h0, free});
        man <= 1'b1;
        @(posedge core_clk_i);
        man <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("free at eleven", 32'h1, {31'h0, free});
        run <= 1'b1;
        // Every source, then extended spacing with timeout gating, then a stretching slave
        for (int k = 0; k < 6; k++)
        begin
            p = per[k % 4];
            ext = (k > 3);
            stretch <= (k == 5) ? 8'd60 : 8'd0;
            apb(1'b1, 8'h04, 32'h0000_005A);
            apb(1'b1, 8'h00, {26'h0, 1'(k == 4), ext, 2'(k % 4), 1'b1});
            // Expectation follows the enable only once the write has landed
            tmo = (k == 4);
            mon = 1'b1;
            phase(lo, hi);
            phase(lo, hi);
            chk("low min", 1, lo >= (k == 5 ? 60 : p));
            chk("high min", 1, hi >= p);
            if (k < 5) chk("bit rate", 1, lo + hi >= 3 * p - 6 && lo + hi <= 3 * p + 6);
            mon = 1'b0;
            apb(1'b1, 8'h00, 32'h0000_0000);
            tmo = 1'b0;
        end
        // Flag after the byte stalls SCL low until software clears it
        stretch <= 8'd0;
        tmo = 1'b0;
        ext = 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0001);
        mon = 1'b1;
        lo = 0;
        while (lo < 150 && cyc < 38000) begin @(negedge core_clk_i); lo = scl ? 0 : lo + 1; end
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk("flag", 32'h1, {31'h0, q[0]});
        apb(1'b1, 8'h08, 32'h0000_0001);
        lo = 0;
        while (scl !== 1'b1 && lo < 100) begin @(negedge core_clk_i); lo++; end
        chk("resume", 1, lo < 100);
        results();
    end
endmodule : test_smbus_timing_core
